/* File: hw/loop_test_pkg.sv */
/*
 * Constants shared by the traffic channel test loopback: register map,
 * field positions, loop type codes, frame sizes and frame timing.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package loop_test_pkg;
    // register byte addresses on the APB
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] STATUS_OFS = 8'h04;
    localparam logic [7:0] DELAY_OFS = 8'h08;
    localparam logic [7:0] COUNT_OFS = 8'h0C;

    // control register fields (write only, self clearing commands)
    localparam int CTRL_CLOSE_BIT = 0;
    localparam int CTRL_OPEN_BIT = 1;
    localparam int CTRL_TYPE_LSB = 4;
    localparam int CTRL_CHAN_LSB = 8;

    // status register fields
    localparam int STAT_CLOSED_BIT = 0;
    localparam int STAT_TCH_BIT = 1;
    localparam int STAT_TYPE_LSB = 4;
    localparam int STAT_CHAN_LSB = 8;

    localparam int TYPE_W = 3;
    localparam int CHAN_W = 3;

    // loop type codes carried in the close request
    localparam logic [2:0] LOOP_A = 3'h0;
    localparam logic [2:0] LOOP_B = 3'h1;
    localparam logic [2:0] LOOP_C = 3'h2;
    localparam logic [2:0] LOOP_D = 3'h3;
    localparam logic [2:0] LOOP_E = 3'h4;
    localparam logic [2:0] LOOP_F = 3'h5;

    // silence descriptor classes
    localparam logic [1:0] SID_ERASED = 2'h0;
    localparam logic [1:0] SID_INVALID = 2'h1;
    localparam logic [1:0] SID_VALID = 2'h2;

    localparam int FRAME_BITS = 260;
    localparam int EFS_BITS = 244;
    localparam int BURST_BITS = 114;
    localparam int REPORT_FRAMES = 104;
    localparam int RTD_LIMIT = 26;
    localparam int RTD_DEFAULT = 5;

    localparam logic [31:0] RESET_WORD = 32'h0000_0000;

    typedef enum logic {
        st_open,
        st_closed
    } loop_state_type;
endpackage

/* File: hw/tch_test_loopback.sv */
/*
 * Traffic channel test loopback: takes close and open commands from
 * software over APB, then routes decoded downlink frames or raw bursts
 * back to the uplink encoder path.
 * Assumes decoder, encoder and burst strobes are synchronous to i_ref_clk
 * and that the frame-slot strobes come from the TDMA frame clock.
 */
// Behaviour
// - close request ignored silently without active channel or while a loop is closed
// - with active channel close loop on named channel and pulse confirmation
// - mode A loops good speech and data frames to the encoder
// - full and half rate channels loop the whole 260-bit frame
// - enhanced full rate channel loops only 244 bits
// - mode A sends zeros for a bad speech frame
// - mode A stolen frame gives zeros; signalling path untouched
// - mode B loops every speech frame with no zero substitution
// - mode C loop starts once the declared delay count of downlink bursts is buffered after the confirmation
// - mode C delay is a fixed declared count below 26 frames; LOOP_ROUND_TRIP_DELAY is not checked against RTD_LIMIT
// - mode C skips uplink control slot and never loops control bursts
// - mode C resends 114 raw burst bits with normal training sequence
// - mode D loops only reliable frames
// - mode D zeros when bad, unreliable or stolen
// - mode E loops valid and invalid silence frames
// - mode E zeros erased silence frames
// - modes E and F zero stolen frames
// - mode F loops only valid silence frames with good flag
// - mode F zeros everything else
// - open request ignored when no loop is closed
`timescale 1ns/1ps
`default_nettype none
module tch_test_loopback
    import loop_test_pkg::*;
#(
    parameter int LOOP_ROUND_TRIP_DELAY = RTD_DEFAULT,
    parameter int DEPTH = 32
) (
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    input wire logic i_tch_active,
    input wire logic i_tch_efs,
    input wire logic i_dec_valid,
    input wire logic [FRAME_BITS-1:0] i_dec_frame,
    input wire logic [CHAN_W-1:0] i_dec_chan,
    input wire logic i_bad_frame_flag,
    input wire logic i_unreliable_frame_flag,
    input wire logic [1:0] i_silence_descriptor_class,
    input wire logic i_stolen,
    input wire logic i_enc_slot,
    input wire logic [FRAME_BITS-1:0] i_norm_frame,
    input wire logic i_dl_burst_valid,
    input wire logic i_dl_burst_assoc,
    input wire logic [BURST_BITS-1:0] i_dl_burst,
    input wire logic i_ul_burst_slot,
    input wire logic i_ul_assoc_slot,
    input wire logic [BURST_BITS-1:0] i_ul_norm_burst,
    output logic o_close_loop_confirm,
    output logic o_loop_closed,
    output logic o_enc_valid,
    output logic [FRAME_BITS-1:0] o_enc_frame,
    output logic o_ul_burst_valid,
    output logic [BURST_BITS-1:0] o_ul_burst
);
    localparam int PW = $clog2(DEPTH);
    localparam logic [PW:0] RTD_CNT = (PW+1)'(LOOP_ROUND_TRIP_DELAY);

    loop_state_type state_r;
    logic [TYPE_W-1:0] type_r;
    logic [CHAN_W-1:0] chan_r;
    logic [15:0] confirm_cnt_r;
    logic wr_acc, rd_acc;
    logic close_cmd, open_cmd, close_ok;
    logic [FRAME_BITS-1:0] held_r;
    logic keep;
    logic [FRAME_BITS-1:0] efs_mask;
    logic [BURST_BITS-1:0] ring_r [DEPTH];
    logic [PW-1:0] wr_ptr_r, rd_ptr_r;
    logic [PW:0] fill_r;
    logic primed_r;
    logic is_c, push, pop;

    assign wr_acc = i_psel && i_penable && o_pready && i_pwrite;
    assign rd_acc = i_psel && !i_penable && !i_pwrite;
    assign close_cmd = wr_acc && i_paddr == CTRL_OFS
        && i_pwdata[CTRL_CLOSE_BIT];
    assign open_cmd = wr_acc && i_paddr == CTRL_OFS
        && i_pwdata[CTRL_OPEN_BIT] && !i_pwdata[CTRL_CLOSE_BIT];
    assign close_ok = close_cmd && i_tch_active && state_r == st_open;

    // zero wait state: ready rises in the access phase of every transfer
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_pready <= 1'b0;
            o_pslverr <= 1'b0;
            o_prdata <= RESET_WORD;
        end else begin
            o_pready <= i_psel && !i_penable;
            o_pslverr <= i_psel && !i_penable && i_paddr != CTRL_OFS
                && i_paddr != STATUS_OFS && i_paddr != DELAY_OFS
                && i_paddr != COUNT_OFS;
            o_prdata <= RESET_WORD;
            if (rd_acc) begin
                case (i_paddr)
                    STATUS_OFS: begin
                        o_prdata[STAT_CLOSED_BIT] <= state_r == st_closed;
                        o_prdata[STAT_TCH_BIT] <= i_tch_active;
                        o_prdata[STAT_TYPE_LSB +: TYPE_W] <= type_r;
                        o_prdata[STAT_CHAN_LSB +: CHAN_W] <= chan_r;
                    end
                    DELAY_OFS: o_prdata <= 32'(LOOP_ROUND_TRIP_DELAY);
                    COUNT_OFS: o_prdata <= {16'h0000, confirm_cnt_r};
                    default: o_prdata <= RESET_WORD;
                endcase
            end
        end
    end

    // loop state; an open request with no loop closed falls through
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_r <= st_open;
            type_r <= LOOP_A;
            chan_r <= '0;
        end else begin
            case (state_r)
                st_open: begin
                    if (close_ok) begin
                        state_r <= st_closed;
                        type_r <= i_pwdata[CTRL_TYPE_LSB +: TYPE_W];
                        chan_r <= i_pwdata[CTRL_CHAN_LSB +: CHAN_W];
                    end
                end
                st_closed: begin
                    if (open_cmd) begin
                        state_r <= st_open;
                    end
                end
                default: state_r <= st_open;
            endcase
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_close_loop_confirm <= 1'b0;
            o_loop_closed <= 1'b0;
            confirm_cnt_r <= 16'h0000;
        end else begin
            o_close_loop_confirm <= close_ok;
            o_loop_closed <= close_ok || (state_r == st_closed && !open_cmd);
            if (close_ok) begin
                confirm_cnt_r <= confirm_cnt_r + 16'h0001;
            end
        end
    end

    // which decoded frames survive; everything else goes up as zeros
    always_comb begin
        keep = 1'b0;
        case (type_r)
            LOOP_A: keep = !i_bad_frame_flag && !i_stolen;
            LOOP_B: keep = 1'b1;
            LOOP_D: keep = !i_bad_frame_flag && !i_unreliable_frame_flag
                && !i_stolen;
            LOOP_E: keep = i_silence_descriptor_class != SID_ERASED
                && !i_stolen;
            LOOP_F: keep = i_silence_descriptor_class == SID_VALID
                && !i_bad_frame_flag && !i_unreliable_frame_flag
                && !i_stolen;
            default: keep = 1'b0;
        endcase
    end

    // the enhanced rate frame is shorter; its unused top bits go up as zero
    assign efs_mask = i_tch_efs
        ? {{(FRAME_BITS-EFS_BITS){1'b0}}, {EFS_BITS{1'b1}}}
        : {FRAME_BITS{1'b1}};

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            held_r <= '0;
        end else if (i_dec_valid && i_dec_chan == chan_r) begin
            held_r <= keep ? (i_dec_frame & efs_mask) : '0;
        end
    end

    // frames leave only on the encoder slot strobe, so uplink timing holds
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_enc_valid <= 1'b0;
            o_enc_frame <= '0;
        end else begin
            o_enc_valid <= i_enc_slot;
            if (i_enc_slot) begin
                o_enc_frame <= (state_r == st_closed && type_r != LOOP_C)
                    ? held_r : i_norm_frame;
            end
        end
    end

    // burst ring: the fixed delay is the priming depth, counted in TCH slots
    assign is_c = state_r == st_closed && type_r == LOOP_C;
    assign push = is_c && i_dl_burst_valid && !i_dl_burst_assoc;
    assign pop = is_c && primed_r && i_ul_burst_slot && !i_ul_assoc_slot
        && fill_r != '0;

    generate
        for (genvar g = 0; g < DEPTH; g++) begin : g_ring
            always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
                if (!i_rst_n) begin
                    ring_r[g] <= '0;
                end else if (push && wr_ptr_r == PW'(g)) begin
                    ring_r[g] <= i_dl_burst;
                end
            end
        end
    endgenerate

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            fill_r <= '0;
            primed_r <= 1'b0;
        end else if (!is_c) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            fill_r <= '0;
            primed_r <= 1'b0;
        end else begin
            if (push) begin
                wr_ptr_r <= wr_ptr_r + 1'b1;
            end
            if (pop) begin
                rd_ptr_r <= rd_ptr_r + 1'b1;
            end
            fill_r <= fill_r + (push ? 1'b1 : 1'b0) - (pop ? 1'b1 : 1'b0);
            if (fill_r == RTD_CNT) begin
                primed_r <= 1'b1;
            end
        end
    end

    // the uplink control slot keeps its place; normal source fills it
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_ul_burst_valid <= 1'b0;
            o_ul_burst <= '0;
        end else begin
            o_ul_burst_valid <= i_ul_burst_slot;
            if (i_ul_burst_slot) begin
                o_ul_burst <= pop ? ring_r[rd_ptr_r] : i_ul_norm_burst;
            end
        end
    end

    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (!i_rst_n);

    a_close_ignored: assert property (
        close_cmd && (!i_tch_active || state_r == st_closed)
        |=> !o_close_loop_confirm)
        else $error("close request acted on while not allowed");
    a_close_confirm: assert property (
        close_cmd && i_tch_active && state_r == st_open
        |=> o_close_loop_confirm && state_r == st_closed
            ##1 !o_close_loop_confirm)
        else $error("close request not confirmed");
    a_open_ignored: assert property (
        open_cmd && state_r == st_open && !close_cmd |=> state_r == st_open)
        else $error("open request changed an open loop");
    a_type_held: assert property (
        state_r == st_closed && !open_cmd |=> $stable(type_r) && $stable(chan_r))
        else $error("loop type changed while closed");
    a_enc_slot: assert property (
        o_enc_valid |-> $past(i_enc_slot))
        else $error("encoder frame outside its slot");
    a_open_normal: assert property (
        state_r == st_open && i_enc_slot |=> o_enc_frame == $past(i_norm_frame))
        else $error("open loop did not use normal source");
    a_zero_bad: assert property (
        state_r == st_closed && type_r == LOOP_A && i_dec_valid
        && i_dec_chan == chan_r && i_bad_frame_flag |=> held_r == '0)
        else $error("bad frame not zeroed in mode A");
    a_zero_unrel: assert property (
        type_r == LOOP_D && i_dec_valid && i_dec_chan == chan_r
        && i_unreliable_frame_flag |=> held_r == '0)
        else $error("unreliable frame not zeroed in mode D");
    a_sid_valid: assert property (
        type_r == LOOP_F && i_dec_valid && i_dec_chan == chan_r
        && i_silence_descriptor_class != SID_VALID |=> held_r == '0)
        else $error("non valid silence frame looped in mode F");
    a_efs_width: assert property (
        i_tch_efs && i_dec_valid && i_dec_chan == chan_r
        |=> held_r[FRAME_BITS-1:EFS_BITS] == '0)
        else $error("enhanced rate frame wider than allowed");
    a_no_assoc_loop: assert property (
        i_ul_assoc_slot |-> !pop)
        else $error("looped burst sent in control slot");
    a_delay_limit: assert property (
        is_c |-> fill_r <= RTD_CNT + 1'b1)
        else $error("burst delay exceeds declared value");

    // per-mode and other-channel checks on the stored frame, one edge after the decoder strobe; then open, burst ring and control slot checks
    a_good_looped: assert property (
        state_r == st_closed && type_r == LOOP_A && i_dec_valid
        && i_dec_chan == chan_r && !i_bad_frame_flag && !i_stolen
        && !i_tch_efs |=> held_r == $past(i_dec_frame))
        else $error("good frame not looped in mode A");
    a_plain_looped: assert property (
        type_r == LOOP_B && i_dec_valid && i_dec_chan == chan_r
        && !i_tch_efs |=> held_r == $past(i_dec_frame))
        else $error("speech frame not looped in mode B");
    a_efs_looped: assert property (
        type_r == LOOP_B && i_dec_valid && i_dec_chan == chan_r
        && i_tch_efs
        |=> held_r[EFS_BITS-1:0] == $past(i_dec_frame[EFS_BITS-1:0]))
        else $error("enhanced rate bits not looped");
    a_reliable_looped: assert property (
        type_r == LOOP_D && i_dec_valid && i_dec_chan == chan_r
        && !i_bad_frame_flag && !i_unreliable_frame_flag && !i_stolen
        && !i_tch_efs |=> held_r == $past(i_dec_frame))
        else $error("reliable frame not looped in mode D");
    a_sid_looped: assert property (
        type_r == LOOP_E && i_dec_valid && i_dec_chan == chan_r
        && i_silence_descriptor_class != SID_ERASED && !i_stolen
        && !i_tch_efs |=> held_r == $past(i_dec_frame))
        else $error("silence frame not looped in mode E");
    a_sid_erased: assert property (
        type_r == LOOP_E && i_dec_valid && i_dec_chan == chan_r
        && i_silence_descriptor_class == SID_ERASED |=> held_r == '0)
        else $error("erased silence frame looped in mode E");
    a_stolen_zero: assert property (
        (type_r == LOOP_E || type_r == LOOP_F) && i_dec_valid
        && i_dec_chan == chan_r && i_stolen |=> held_r == '0)
        else $error("stolen frame looped in a silence mode");
    a_flagged_zero: assert property (
        type_r == LOOP_F && i_dec_valid && i_dec_chan == chan_r
        && (i_bad_frame_flag || i_unreliable_frame_flag) |=> held_r == '0)
        else $error("flagged frame looped in mode F");
    a_other_chan: assert property (
        i_dec_valid && i_dec_chan != chan_r |=> $stable(held_r))
        else $error("frame of another channel stored");
    a_open_done: assert property (
        state_r == st_closed && open_cmd
        |=> state_r == st_open && !o_loop_closed)
        else $error("open request left the loop closed");
    a_burst_primed: assert property (
        is_c && fill_r == RTD_CNT |=> primed_r)
        else $error("burst loop not working after the declared delay");
    a_burst_order: assert property (
        pop |=> o_ul_burst == $past(ring_r[rd_ptr_r]))
        else $error("looped burst out of order");
    a_ctrl_slot: assert property (
        i_ul_burst_slot && i_ul_assoc_slot
        |=> o_ul_burst == $past(i_ul_norm_burst))
        else $error("control slot did not carry the normal burst");

    c_close_a: cover property (o_close_loop_confirm && type_r == LOOP_A);
    c_burst_loop: cover property (pop ##1 o_ul_burst_valid);
    c_open_after: cover property (state_r == st_closed ##1 state_r == st_open);
    c_sid_e: cover property (type_r == LOOP_E && i_dec_valid && keep);
    c_ctrl_skip: cover property (is_c && i_ul_burst_slot && i_ul_assoc_slot);
endmodule
`default_nettype wire

/* File: testbench/sim_station.sv */
/* far-side model: tester's acknowledgement supervision timer.
   assumes request and confirm pulses are synchronous to i_clk. */
`timescale 1ns/1ps
`default_nettype none
module sim_station (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_req_sent,
    input wire logic i_confirm,
    output logic o_timer_run,
    output logic [15:0] o_timer_cnt
);
    // confirm wins over a new request: the timer must stop on the answer
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_timer_run <= 1'b0;
            o_timer_cnt <= 16'h0000;
        end else if (i_confirm) begin
            o_timer_run <= 1'b0;
        end else if (i_req_sent) begin
            o_timer_run <= 1'b1;
            o_timer_cnt <= 16'h0000;
        end else if (o_timer_run) begin
            o_timer_cnt <= o_timer_cnt + 16'h0001;
        end
    end
endmodule
`default_nettype wire

/* File: testbench/tch_test_loopback_tb.sv */
/* bench for the test loopback: registers, close and open, frame
   substitution for every loop type, burst loop delay.
   assumes the package and the far-side model are compiled first. */
`timescale 1ns/1ps
`default_nettype none
module tch_test_loopback_tb;
    import loop_test_pkg::*;
    localparam int RTD_TB = 5;
    localparam logic [259:0] PAT = {4'h9, {8{32'hC3A5_1E0F}}};
    localparam logic [259:0] NORM = {4'h6, {8{32'h5A3C_E187}}};
    localparam logic [113:0] UL_NORM = {3{38'h15_5555_5555}};
    logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, tch = 1'b0, efs = 1'b0, dv = 1'b0, es = 1'b0;
    logic bad_frame_flag = 1'b0, unreliable_frame_flag = 1'b0, stl = 1'b0, dlv = 1'b0, dla = 1'b0;
    logic uls = 1'b0, ula = 1'b0, req = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rdat;
    logic [1:0] silence_descriptor_class = 2'h0;
    logic [2:0] dch = 3'h2;
    logic [259:0] efr;
    logic [113:0] dlb = 114'h0, ulb;
    logic pready, pslverr, conf, closed, ev, ulv, rerr, trun;
    int fail_count = 0, num_checks = 0, cyc = 0, p, q;

    tch_test_loopback #(.LOOP_ROUND_TRIP_DELAY(RTD_TB), .DEPTH(32)) DUT (
        .i_ref_clk(clk), .i_rst_n(rst_n), .i_psel(psel),
        .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
        .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
        .o_pslverr(pslverr), .i_tch_active(tch), .i_tch_efs(efs),
        .i_dec_valid(dv), .i_dec_frame(PAT), .i_dec_chan(dch),
        .i_bad_frame_flag(bad_frame_flag), .i_unreliable_frame_flag(unreliable_frame_flag),
        .i_silence_descriptor_class(silence_descriptor_class), .i_stolen(stl),
        .i_enc_slot(es), .i_norm_frame(NORM), .i_dl_burst_valid(dlv),
        .i_dl_burst_assoc(dla), .i_dl_burst(dlb),
        .i_ul_burst_slot(uls), .i_ul_assoc_slot(ula),
        .i_ul_norm_burst(UL_NORM), .o_close_loop_confirm(conf),
        .o_loop_closed(closed), .o_enc_valid(ev), .o_enc_frame(efr),
        .o_ul_burst_valid(ulv), .o_ul_burst(ulb));
    sim_station SIM (.i_clk(clk), .i_rst_n(rst_n), .i_req_sent(req),
        .i_confirm(conf), .o_timer_run(trun), .o_timer_cnt());

    always #12.5 clk = ~clk;

    task automatic end_sim();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // whole run is well under a thousand cycles
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            fail_count++;
            end_sim();
        end
    end

    task automatic chk(input string n, input logic [259:0] e,
                       input logic [259:0] g);
        num_checks++;
        if (g !== e) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        req <= w && a == CTRL_OFS && d[0];
        @(posedge clk);
        penable <= 1'b1;
        req <= 1'b0;
        // no answer time assumed: only the bench timeout ends this wait
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic close_loop(input logic [2:0] t, input logic cf,
                              input logic cl);
        apb(1'b1, CTRL_OFS, 32'h201 | (32'(t) << CTRL_TYPE_LSB));
        #1;
        chk("confirm", cf, conf);
        chk("closed", cl, closed);
        @(posedge clk);
        #1;
        chk("confirm end", 1'b0, conf);
        chk("timer", !cf, trun);
    endtask

    // src: 0 zeroed, 1 looped, 2 normal encoder input
    task automatic frame(input logic b, u, input logic [1:0] s,
                         input logic st, e, input int src);
        logic [259:0] x;
        x = e ? {16'h0, PAT[243:0]} : PAT;
        x = src == 2 ? NORM : (src == 1 ? x : 260'h0);
        @(posedge clk);
        dv <= 1'b1;
        bad_frame_flag <= b;
        unreliable_frame_flag <= u;
        silence_descriptor_class <= s;
        stl <= st;
        efs <= e;
        @(posedge clk);
        dv <= 1'b0;
        @(posedge clk);
        es <= 1'b1;
        @(posedge clk);
        es <= 1'b0;
        #1;
        chk("enc_valid", 1'b1, ev);
        chk("enc_frame", x, efr);
    endtask

    task automatic open_loop();
        apb(1'b1, CTRL_OFS, 32'h2);
        #1;
        chk("open", 1'b0, closed);
        frame(0, 0, 2'h2, 0, 0, 2);
    endtask

    task automatic regs_reset();
        apb(1'b0, DELAY_OFS, 32'h0);
        chk("delay", RTD_TB, rdat);
        apb(1'b0, COUNT_OFS, 32'h0);
        chk("count", 32'h0, rdat);
        apb(1'b0, 8'h10, 32'h0);
        chk("unmapped", 1'b1, rerr);
    endtask

    task automatic close_refused();
        close_loop(LOOP_A, 0, 0);
        @(posedge clk);
        tch <= 1'b1;
        close_loop(LOOP_E, 1, 1);
        close_loop(LOOP_A, 0, 1);
        apb(1'b0, STATUS_OFS, 32'h0);
        chk("status", 32'h243, rdat);
        apb(1'b0, COUNT_OFS, 32'h0);
        chk("count", 32'h1, rdat);
        open_loop();
        open_loop();
    endtask

    task automatic modes_abd();
        close_loop(LOOP_A, 1, 1);
        frame(0, 0, 2'h2, 0, 0, 1);
        // a bad frame on another channel must leave the stored frame alone
        @(posedge clk);
        dch <= 3'h5;
        frame(1, 0, 2'h2, 0, 0, 1);
        @(posedge clk);
        dch <= 3'h2;
        frame(1, 0, 2'h2, 0, 0, 0);
        frame(0, 0, 2'h2, 1, 0, 0);
        frame(0, 0, 2'h2, 0, 1, 1);
        open_loop();
        // no stolen frames while the plain loop runs
        close_loop(LOOP_B, 1, 1);
        frame(1, 0, 2'h0, 0, 0, 1);
        frame(0, 1, 2'h0, 0, 1, 1);
        open_loop();
        close_loop(LOOP_D, 1, 1);
        frame(0, 0, 2'h2, 0, 0, 1);
        frame(0, 1, 2'h2, 0, 0, 0);
        frame(1, 0, 2'h2, 0, 0, 0);
        frame(0, 0, 2'h2, 1, 0, 0);
        open_loop();
    endtask

    task automatic modes_ef();
        close_loop(LOOP_E, 1, 1);
        frame(0, 0, 2'h1, 0, 0, 1);
        frame(0, 0, 2'h0, 0, 0, 0);
        frame(0, 0, 2'h2, 1, 0, 0);
        open_loop();
        close_loop(LOOP_F, 1, 1);
        frame(0, 0, 2'h2, 0, 0, 1);
        frame(0, 0, 2'h1, 0, 0, 0);
        frame(0, 1, 2'h2, 0, 0, 0);
        frame(1, 0, 2'h2, 0, 0, 0);
        frame(0, 0, 2'h2, 1, 0, 0);
        open_loop();
    endtask

    // one uplink slot then one downlink burst per frame; a control
    // frame in the middle must neither pop nor push
    task automatic mode_c();
        logic [113:0] x;
        close_loop(LOOP_C, 1, 1);
        frame(0, 0, 2'h2, 0, 0, 2);
        p = 0;
        q = 0;
        for (int k = 0; k < RTD_TB + 5; k++) begin
            @(posedge clk);
            uls <= 1'b1;
            ula <= (k == RTD_TB + 2);
            x = UL_NORM;
            if (k != RTD_TB + 2 && p >= RTD_TB) begin
                x = 114'(32'hB000_0000 + q);
                q++;
            end
            @(posedge clk);
            uls <= 1'b0;
            #1;
            chk("ul_valid", 1'b1, ulv);
            chk("ul_burst", x, ulb);
            @(posedge clk);
            dlv <= 1'b1;
            dla <= (k == RTD_TB + 2);
            dlb <= 114'(32'hB000_0000 + p);
            if (k != RTD_TB + 2) p++;
            @(posedge clk);
            dlv <= 1'b0;
        end
        open_loop();
    endtask

    initial begin
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        regs_reset();
        close_refused();
        modes_abd();
        modes_ef();
        mode_c();
        end_sim();
    end
endmodule
`default_nettype wire
